/* File: rtl/oled_port_pkg.sv */
// Purpose: Shared constants for the serial command/data port
// Assumes: 32-bit register port, byte offsets
// Notes:   Reset values follow the controller power-on state
package oled_port_pkg;

    // Register offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_CONFIG   = 8'h08;
    localparam logic [7:0] REG_LAST     = 8'h0c;

    // Field positions
    localparam int CTRL_RX_EN   = 0;
    localparam int ST_DISP_ON   = 0;
    localparam int ST_ENTIRE    = 1;
    localparam int ST_INVERSE   = 2;
    localparam int ST_SEG_REMAP = 3;
    localparam int ST_COM_REV   = 4;
    localparam int ST_BUSY      = 5;
    localparam int CFG_CONTRAST = 0;
    localparam int CFG_START    = 8;
    localparam int CFG_MUX      = 16;
    localparam int CFG_COL      = 24;
    localparam int LAST_IS_DATA = 8;

    // Reset values
    localparam logic       RST_RX_EN    = 1'h1;
    localparam logic [7:0] RST_CONTRAST = 8'h7f;
    localparam logic [5:0] RST_MUX      = 6'h3f;
    localparam logic [5:0] RST_START    = 6'h00;
    localparam logic [6:0] RST_COL      = 7'h00;
    localparam logic [6:0] COL_LAST     = 7'h7f;
    // Pin sync reset: hw_reset_n, cs_n, dc, sclk, sdata
    // Deselected with the link clock idle low, so no false clock edge follows reset
    localparam logic [4:0] PIN_RST      = 5'h08;

    // Command codes
    localparam logic [7:0] CMD_DISP_OFF = 8'hae;
    localparam logic [7:0] CMD_DISP_ON  = 8'haf;
    localparam logic [7:0] CMD_RAM_SHOW = 8'ha4;
    localparam logic [7:0] CMD_ALL_ON   = 8'ha5;
    localparam logic [7:0] CMD_NORMAL   = 8'ha6;
    localparam logic [7:0] CMD_INVERSE  = 8'ha7;
    localparam logic [7:0] CMD_SEG_NORM = 8'ha0;
    localparam logic [7:0] CMD_SEG_REV  = 8'ha1;
    localparam logic [7:0] CMD_COM_NORM = 8'hc0;
    localparam logic [7:0] CMD_COM_REV  = 8'hc8;
    localparam logic [7:0] CMD_CONTRAST = 8'h81;
    localparam logic [7:0] CMD_MUX      = 8'ha8;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_GET_CONT = 2'b01,
        ST_GET_MUX  = 2'b10
    } cmd_state_t;

endpackage

/* File: rtl/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to i_clk_sys
// Notes:   Output moves only when stages two and three agree
module pin_sync #(
    parameter int         WIDTH   = 1,
    parameter logic [4:0] RST_VAL = 5'h00
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            s1_q    <= RST_VAL[WIDTH-1:0];
            s2_q    <= RST_VAL[WIDTH-1:0];
            s3_q    <= RST_VAL[WIDTH-1:0];
            o_level <= RST_VAL[WIDTH-1:0];
        end
        else
        begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2_q[i] == s3_q[i])
                    o_level[i] <= s3_q[i];
            end
        end
    end
endmodule

/* File: rtl/serial_shift.sv */
// Purpose: Assembles serial bits into bytes
// Assumes: Synchronised pins and a one-cycle serial clock rise strobe
// Notes:   Bit counter restarts whenever the select goes high
module serial_shift (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_enable,
    input  wire logic       i_sclk_rise,
    input  wire logic       i_cs_n,
    input  wire logic       i_dc,
    input  wire logic       i_sdata,
    output logic      [7:0] o_byte,
    output logic            o_is_data,
    output logic            o_valid,
    output logic            o_busy
);
    logic [2:0] cnt_q;
    logic [6:0] sh_q;
    logic       dc_q;
    logic       take;

    assign take   = i_sclk_rise && !i_cs_n && i_enable;
    assign o_busy = (cnt_q != 3'h0);

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || i_cs_n)
        begin
            cnt_q <= 3'h0;
            sh_q  <= 7'h00;
        end
        else if (take)
        begin
            cnt_q <= cnt_q + 3'h1;
            sh_q  <= {sh_q[5:0], i_sdata};
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            dc_q <= 1'h0;
        else if (take && cnt_q == 3'h0)
            dc_q <= i_dc;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            o_valid   <= 1'h0;
            o_byte    <= 8'h00;
            o_is_data <= 1'h0;
        end
        else
        begin
            o_valid <= take && cnt_q == 3'h7;
            if (take && cnt_q == 3'h7)
            begin
                o_byte    <= {sh_q, i_sdata};
                o_is_data <= dc_q;
            end
        end
    end

    a_msb_order: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_valid |-> o_byte[0] == $past(i_sdata) && o_byte[7:1] == $past(sh_q))
        else $error("Byte not assembled msb first");
endmodule

/* File: rtl/oled_serial_port.sv */
// Purpose: Serial command/data input port of a passive-matrix display controller
// Assumes: Host drives clock, data and selects; no read path on the link
// Notes:   Link pins are oversampled by i_clk_sys, so the link clock must stay slow
//
// The address map and strobed register access were left to the implementer.
module oled_serial_port (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_hw_reset_n,
    input  wire logic        i_cs_n,
    input  wire logic        i_dc,
    input  wire logic        i_sclk,
    input  wire logic        i_serial_data_in,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rd_data,
    output logic             o_display_on,
    output logic             o_entire_on,
    output logic             o_inverse,
    output logic             o_seg_remap,
    output logic             o_com_rev,
    output logic      [7:0]  o_contrast,
    output logic      [5:0]  o_mux_ratio,
    output logic      [5:0]  o_start_line,
    output logic      [6:0]  o_col_addr,
    output logic      [7:0]  o_data_byte,
    output logic             o_data_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [4:0] pins_s;
    logic       hw_rst_n_s;
    logic       cs_n_s;
    logic       dc_s;
    logic       sclk_s;
    logic       sdata_s;
    logic       sclk_prev_q;
    logic       sclk_rise;
    logic       init_n;

    pin_sync #(
        .WIDTH   (5),
        .RST_VAL (oled_port_pkg::PIN_RST)
    ) u_pins (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_pin     ({i_hw_reset_n, i_cs_n, i_dc, i_sclk, i_serial_data_in}),
        .o_level   (pins_s)
    );

    assign {hw_rst_n_s, cs_n_s, dc_s, sclk_s, sdata_s} = pins_s;
    // Sync reset value holds hardware reset active until the pin is seen high
    assign init_n    = i_rstn && hw_rst_n_s;
    assign sclk_rise = sclk_s && !sclk_prev_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            sclk_prev_q <= 1'h0;
        else
            sclk_prev_q <= sclk_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte assembly
    logic       rx_en_q;
    logic [7:0] rx_byte;
    logic       rx_is_data;
    logic       rx_valid;
    logic       rx_busy;

    serial_shift u_shift (
        .i_clk_sys   (i_clk_sys),
        .i_rstn      (init_n),
        .i_enable    (rx_en_q),
        .i_sclk_rise (sclk_rise),
        .i_cs_n      (cs_n_s),
        .i_dc        (dc_s),
        .i_sdata     (sdata_s),
        .o_byte      (rx_byte),
        .o_is_data   (rx_is_data),
        .o_valid     (rx_valid),
        .o_busy      (rx_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command decoder and controller state
    oled_port_pkg::cmd_state_t state_q;
    logic       disp_on_q;
    logic       entire_q;
    logic       inverse_q;
    logic       seg_remap_q;
    logic       com_rev_q;
    logic [7:0] contrast_q;
    logic [5:0] mux_q;
    logic [5:0] start_q;
    logic [6:0] col_q;
    logic [7:0] data_q;
    logic       data_vld_q;
    logic [7:0] last_q;
    logic       last_dc_q;
    logic       cmd_vld;

    assign cmd_vld = rx_valid && !rx_is_data;

    always_ff @(posedge i_clk_sys)
    begin
        if (!init_n)
        begin
            state_q     <= oled_port_pkg::ST_IDLE;
            disp_on_q   <= 1'h0;
            entire_q    <= 1'h0;
            inverse_q   <= 1'h0;
            seg_remap_q <= 1'h0;
            com_rev_q   <= 1'h0;
            contrast_q  <= oled_port_pkg::RST_CONTRAST;
            mux_q       <= oled_port_pkg::RST_MUX;
            start_q     <= oled_port_pkg::RST_START;
        end
        else if (cmd_vld)
        begin
            case (state_q)
                oled_port_pkg::ST_GET_CONT:
                begin
                    contrast_q <= rx_byte;
                    state_q    <= oled_port_pkg::ST_IDLE;
                end
                oled_port_pkg::ST_GET_MUX:
                begin
                    mux_q   <= rx_byte[5:0];
                    state_q <= oled_port_pkg::ST_IDLE;
                end
                oled_port_pkg::ST_IDLE:
                begin
                    case (rx_byte)
                        oled_port_pkg::CMD_DISP_OFF: disp_on_q   <= 1'h0;
                        oled_port_pkg::CMD_DISP_ON:  disp_on_q   <= 1'h1;
                        oled_port_pkg::CMD_RAM_SHOW: entire_q    <= 1'h0;
                        oled_port_pkg::CMD_ALL_ON:   entire_q    <= 1'h1;
                        oled_port_pkg::CMD_NORMAL:   inverse_q   <= 1'h0;
                        oled_port_pkg::CMD_INVERSE:  inverse_q   <= 1'h1;
                        oled_port_pkg::CMD_SEG_NORM: seg_remap_q <= 1'h0;
                        oled_port_pkg::CMD_SEG_REV:  seg_remap_q <= 1'h1;
                        oled_port_pkg::CMD_COM_NORM: com_rev_q   <= 1'h0;
                        oled_port_pkg::CMD_COM_REV:  com_rev_q   <= 1'h1;
                        oled_port_pkg::CMD_CONTRAST: state_q     <= oled_port_pkg::ST_GET_CONT;
                        oled_port_pkg::CMD_MUX:      state_q     <= oled_port_pkg::ST_GET_MUX;
                        default:
                        begin
                            // Start line lives in codes 40..7f
                            if (rx_byte[7:6] == 2'h1)
                                start_q <= rx_byte[5:0];
                        end
                    endcase
                end
                default: state_q <= oled_port_pkg::ST_IDLE;
            endcase
        end
    end

    // Column counter: set by commands, advanced by each data byte
    always_ff @(posedge i_clk_sys)
    begin
        if (!init_n)
            col_q <= oled_port_pkg::RST_COL;
        else if (rx_valid && rx_is_data)
            col_q <= col_q + 7'h01;
        else if (cmd_vld && state_q == oled_port_pkg::ST_IDLE && rx_byte[7:4] == 4'h0)
            col_q <= {col_q[6:4], rx_byte[3:0]};
        else if (cmd_vld && state_q == oled_port_pkg::ST_IDLE && rx_byte[7:3] == 5'h02)
            col_q <= {rx_byte[2:0], col_q[3:0]};
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!init_n)
        begin
            data_q     <= 8'h00;
            data_vld_q <= 1'h0;
        end
        else
        begin
            data_vld_q <= rx_valid && rx_is_data;
            if (rx_valid && rx_is_data)
                data_q <= rx_byte;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!init_n)
        begin
            last_q    <= 8'h00;
            last_dc_q <= 1'h0;
        end
        else if (rx_valid)
        begin
            last_q    <= rx_byte;
            last_dc_q <= rx_is_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port
    // Receive enable survives a hardware reset so software keeps control
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            rx_en_q <= oled_port_pkg::RST_RX_EN;
        else if (i_wr && i_addr == oled_port_pkg::REG_CTRL)
            rx_en_q <= i_wr_data[oled_port_pkg::CTRL_RX_EN];
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            o_rd_data <= 32'h0000_0000;
        else if (i_rd)
        begin
            case (i_addr)
                oled_port_pkg::REG_CTRL:
                    o_rd_data <= {31'h0000_0000, rx_en_q};
                oled_port_pkg::REG_STATUS:
                    o_rd_data <= {26'h000_0000, rx_busy, com_rev_q, seg_remap_q,
                                  inverse_q, entire_q, disp_on_q};
                oled_port_pkg::REG_CONFIG:
                    o_rd_data <= {1'h0, col_q, 2'h0, mux_q, 2'h0, start_q, contrast_q};
                oled_port_pkg::REG_LAST:
                    o_rd_data <= {23'h00_0000, last_dc_q, last_q};
                default:
                    o_rd_data <= 32'h0000_0000;
            endcase
        end
        else
            o_rd_data <= 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_display_on = disp_on_q;
    assign o_entire_on  = entire_q;
    assign o_inverse    = inverse_q;
    assign o_seg_remap  = seg_remap_q;
    assign o_com_rev    = com_rev_q;
    assign o_contrast   = contrast_q;
    assign o_mux_ratio  = mux_q;
    assign o_start_line = start_q;
    assign o_col_addr   = col_q;
    assign o_data_byte  = data_q;
    assign o_data_valid = data_vld_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_cs_gates_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        cs_n_s |=> !rx_valid)
        else $error("Byte accepted while deselected");

    a_data_moves_col: assert property (@(posedge i_clk_sys) disable iff (!init_n)
        rx_valid && rx_is_data |=> col_q == $past(col_q) + 7'h01 && data_vld_q)
        else $error("Data byte did not advance column");

    a_cmd_not_data: assert property (@(posedge i_clk_sys) disable iff (!init_n)
        cmd_vld |=> !data_vld_q)
        else $error("Command byte leaked to data output");

    a_display_on_cmd: assert property (@(posedge i_clk_sys) disable iff (!init_n)
        cmd_vld && state_q == oled_port_pkg::ST_IDLE && rx_byte == oled_port_pkg::CMD_DISP_ON
        |=> disp_on_q)
        else $error("Display on command not acted on");

    a_contrast_pair: assert property (@(posedge i_clk_sys) disable iff (!init_n)
        cmd_vld && state_q == oled_port_pkg::ST_GET_CONT
        |=> contrast_q == $past(rx_byte) && state_q == oled_port_pkg::ST_IDLE)
        else $error("Contrast value not loaded");

    a_reset_display: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !hw_rst_n_s |=> !disp_on_q && mux_q == 6'h3f)
        else $error("Reset did not switch display off");

    a_reset_mapping: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !hw_rst_n_s |=> !seg_remap_q && !com_rev_q)
        else $error("Reset did not restore mapping");

    a_reset_shift: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !hw_rst_n_s |=> !rx_busy [*2])
        else $error("Reset left partial bits");

    a_reset_start: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !hw_rst_n_s |=> start_q == 6'h00 && col_q == 7'h00)
        else $error("Reset left start line or column");

    a_reset_contrast: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !hw_rst_n_s |=> contrast_q == 8'h7f && !entire_q && !inverse_q)
        else $error("Reset left contrast or display mode");

    a_deselect_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(cs_n_s) |=> !rx_busy)
        else $error("Deselect kept bit count");

    a_valid_pulse: assert property (@(posedge i_clk_sys) disable iff (!init_n)
        rx_valid |=> !rx_valid ##1 !rx_valid)
        else $error("Byte strobe longer than one cycle");

    a_data_matches_last: assert property (@(posedge i_clk_sys) disable iff (!init_n)
        data_vld_q |-> data_q == last_q && last_dc_q)
        else $error("Data output differs from last byte");

    a_mux_pair: assert property (@(posedge i_clk_sys) disable iff (!init_n)
        cmd_vld && state_q == oled_port_pkg::ST_GET_MUX
        |=> {2'h0, mux_q} == ($past(rx_byte) & 8'h3f) && state_q == oled_port_pkg::ST_IDLE)
        else $error("Mux ratio not loaded");

    a_start_line_cmd: assert property (@(posedge i_clk_sys) disable iff (!init_n)
        cmd_vld && state_q == oled_port_pkg::ST_IDLE && rx_byte[7:6] == 2'h1
        |=> {2'h1, start_q} == $past(rx_byte))
        else $error("Start line command not acted on");

    c_data_byte:  cover property (@(posedge i_clk_sys) disable iff (!init_n) data_vld_q);
    c_cmd_byte:   cover property (@(posedge i_clk_sys) disable iff (!init_n) cmd_vld);
    c_contrast:   cover property (@(posedge i_clk_sys) disable iff (!init_n)
        cmd_vld && state_q == oled_port_pkg::ST_GET_CONT);
    c_hw_reset:   cover property (@(posedge i_clk_sys) disable iff (!i_rstn) $fell(hw_rst_n_s));
endmodule

/* File: sim/host_model.sv */
// Purpose: Host side of the serial link, drives selects, clock and data
// Assumes: Paced by the bench clock, 8 clocks per link bit (320 ns)
// Notes:   Link clock stands low outside frames; released lines show inverse
module host_model (
    input  wire logic i_clk_sys,
    output logic      o_hw_reset_n,
    output logic      o_cs_n,
    output logic      o_dc,
    output logic      o_sclk,
    output logic      o_sdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_hw_reset_n = 1'h1;
        o_cs_n = 1'h1;
        o_dc = 1'h0;
        o_sclk = 1'h0;
        o_sdata = 1'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    // Sel low leaves the chip deselected; flip turns the data/command line after the first rise
    task automatic send(input logic d, input logic [7:0] b, input int nbits, input logic sel, input logic flip);
        int i;
        @(posedge i_clk_sys);
        o_dc <= d;
        o_cs_n <= ~sel;
        wait_clk(4);
        for (i = 7; i > 7 - nbits; i--)
        begin
            o_sclk <= 1'h0;
            o_sdata <= b[i];
            wait_clk(4);
            o_sclk <= 1'h1;
            wait_clk(4);
            if (flip && i == 7)
                o_dc <= ~d;
        end
        o_sclk <= 1'h0;
        wait_clk(4);
        o_cs_n <= 1'h1;
        o_sdata <= ~o_sdata;
        o_dc <= ~o_dc;
        // Deselect must outlast the pin filter, or a partial byte survives
        wait_clk(4);
    endtask

    // Recovery after noise is a full pin reset
    task automatic hw_reset(input int n);
        @(posedge i_clk_sys);
        o_hw_reset_n <= 1'h0;
        wait_clk(n);
        o_hw_reset_n <= 1'h1;
        wait_clk(8);
    endtask
endmodule

/* File: sim/test_oled_serial_port.sv */
// Purpose: Self-checking bench for the serial command/data port
// Assumes: Host model paces the link; register reads take two cycles
// Notes:   Expected state lives in bench variables, never read back
module test_oled_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys, i_rstn, i_wr, i_rd, hw_n, cs_n, dc, sclk, sdata;
    logic [7:0]  i_addr, o_contrast, o_data_byte, contrast, got_b;
    logic [31:0] i_wr_data, o_rd_data, r;
    logic        o_display_on, o_entire_on, o_inverse, o_seg_remap, o_com_rev, o_data_valid;
    logic [5:0]  o_mux_ratio, o_start_line, mux, start;
    logic [6:0]  o_col_addr, col;
    logic        disp, ent, inv, seg, com;
    logic [1:0]  pend;
    int          errors, n_tests, n_valid, nv0;
    logic [7:0]  cmds [10] = '{8'haf, 8'ha5, 8'ha7, 8'ha1, 8'hc8, 8'ha4, 8'ha6, 8'ha0, 8'hc0, 8'hae};

    host_model i_host_model (.i_clk_sys(i_clk_sys), .o_hw_reset_n(hw_n), .o_cs_n(cs_n), .o_dc(dc),
        .o_sclk(sclk), .o_sdata(sdata));
    oled_serial_port i_oled_serial_port (.i_clk_sys, .i_rstn, .i_hw_reset_n(hw_n), .i_cs_n(cs_n),
        .i_dc(dc), .i_sclk(sclk), .i_serial_data_in(sdata), .i_addr, .i_wr_data, .i_wr, .i_rd,
        .o_rd_data, .o_display_on, .o_entire_on, .o_inverse, .o_seg_remap, .o_com_rev, .o_contrast,
        .o_mux_ratio, .o_start_line, .o_col_addr, .o_data_byte, .o_data_valid);

    always #20 i_clk_sys = ~i_clk_sys;

    always @(posedge i_clk_sys)
        if (o_data_valid === 1'h1)
        begin
            n_valid++;
            got_b = o_data_byte;
        end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] status_word();
        return {27'h0, com, seg, inv, ent, disp};
    endfunction

    function automatic logic [31:0] cfg_word();
        return {1'h0, col, 2'h0, mux, 2'h0, start, contrast};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_clk_sys);
        i_rd <= 1'h0;
        #1 d = o_rd_data;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'h1;
        @(posedge i_clk_sys);
        i_wr <= 1'h0;
    endtask

    task automatic reset_model();
        {disp, ent, inv, seg, com} = 5'h00;
        contrast = 8'h7f;
        mux = 6'h3f;
        start = 6'h00;
        col = 7'h00;
        pend = 2'h0;
    endtask

    task automatic check_all();
        logic [31:0] q;
        rd(8'h04, q);
        chk(q, status_word());
        rd(8'h08, q);
        chk(q, cfg_word());
        chk({27'h0, o_com_rev, o_seg_remap, o_inverse, o_entire_on, o_display_on}, status_word());
        chk({1'h0, o_col_addr, 2'h0, o_mux_ratio, 2'h0, o_start_line, o_contrast}, cfg_word());
    endtask

    task automatic put(input logic d, input logic [7:0] b, input logic flip);
        int nv;
        logic [31:0] q;
        nv = n_valid;
        i_host_model.send(d, b, 8, 1'h1, flip);
        repeat (10) @(posedge i_clk_sys);
        chk(32'(n_valid - nv), {31'h0, d});
        rd(8'h0c, q);
        chk(q, {23'h0, d, b});
        if (d)
        begin
            chk(got_b, b);
            col = col + 7'h01;
        end
        else if (pend != 2'h0)
        begin
            if (pend == 2'h1)
                contrast = b;
            else
                mux = b[5:0];
            pend = 2'h0;
        end
        else
            case (b)
                8'hae, 8'haf: disp = b[0];
                8'ha4, 8'ha5: ent = b[0];
                8'ha6, 8'ha7: inv = b[0];
                8'ha0, 8'ha1: seg = b[0];
                8'hc0, 8'hc8: com = b[3];
                8'h81: pend = 2'h1;
                8'ha8: pend = 2'h2;
                default:
                    if (b[7:6] == 2'h1)
                        start = b[5:0];
                    else if (b[7:4] == 4'h0)
                        col[3:0] = b[3:0];
                    else if (b[7:3] == 5'h02)
                        col[6:4] = b[2:0];
            endcase
        check_all();
    endtask

    task automatic done(input string s);
        $display("Test %s done", s);
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (30000) @(posedge i_clk_sys);
        errors++;
        wrap_up();
    end

    initial
    begin
        i_clk_sys = 1'h0;
        i_rstn = 1'h0;
        {i_wr, i_rd, i_addr, i_wr_data} = 42'h0;
        {errors, n_tests, n_valid} = 96'h0;
        got_b = 8'h00;
        void'($urandom(78004));
        repeat (5) @(posedge i_clk_sys);
        i_rstn <= 1'h1;
        repeat (8) @(posedge i_clk_sys);
        reset_model();
        check_all();
        wr(8'h08, $urandom());
        rd(8'h10, r);
        chk(r, 32'h0);
        check_all();
        done("reset");
        put(1'h0, 8'hae, 1'h0);
        foreach (cmds[k])
            put(1'h0, cmds[k], 1'h0);
        put(1'h0, 8'h81, 1'h0);
        put(1'h0, 8'($urandom()), 1'h0);
        put(1'h0, 8'ha8, 1'h0);
        put(1'h0, 8'($urandom_range(63, 15)), 1'h0);
        put(1'h0, 8'h40 | 8'($urandom_range(63, 0)), 1'h0);
        done("commands");
        put(1'h0, 8'h0e, 1'h0);
        put(1'h0, 8'h17, 1'h0);
        repeat (3)
            put(1'h1, 8'($urandom()), 1'h0);
        put(1'h1, 8'($urandom()), 1'h1);
        done("data");
        i_host_model.send(1'h1, 8'h5a, 3, 1'h1, 1'h0);
        put(1'h1, 8'($urandom()), 1'h0);
        nv0 = n_valid;
        i_host_model.send(1'h1, 8'ha5, 8, 1'h0, 1'h0);
        wr(8'h00, 32'h0);
        i_host_model.send(1'h1, 8'h3c, 8, 1'h1, 1'h0);
        repeat (10) @(posedge i_clk_sys);
        chk(32'(n_valid), 32'(nv0));
        check_all();
        wr(8'h00, 32'h1);
        rd(8'h00, r);
        chk(r, 32'h1);
        done("select");
        fork
            i_host_model.send(1'h1, 8'hff, 8, 1'h1, 1'h0);
            begin
                repeat (30) @(posedge i_clk_sys);
                rd(8'h04, r);
                chk({31'h0, r[5]}, 32'h1);
                i_host_model.hw_reset(6);
            end
        join
        reset_model();
        check_all();
        put(1'h1, 8'($urandom()), 1'h0);
        put(1'h0, 8'hae, 1'h0);
        done("reset pin");
        wrap_up();
    end
endmodule
